// ==== gcca_clk_seen.sv ====
module gcca_clk_seen
    import gcca_pkg::*;
#(
    parameter int LOST_CYC = GCCA_LINE_CLK_LOST_CYC
) (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic edge_in,
    input wire logic clr_in,
    output logic seen_out,
    output logic alive_out
);

    if (LOST_CYC < 2 || LOST_CYC > 65535) begin : g_bad_lost_cyc
        $error("LOST_CYC out of range");
    end

    logic first_q;
    logic [15:0] idle_q;

    // ------------------------------------------------------------
    // activity flag
    // ------------------------------------------------------------
    // second edge sets
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            seen_out <= 1'b0;
            first_q <= 1'b0;
        end else if (edge_in && !seen_out && first_q) begin
            seen_out <= 1'b1;
            first_q <= 1'b0;
        end else if (clr_in) begin
            seen_out <= 1'b0;
            first_q <= edge_in;
        end else if (edge_in && !seen_out) begin
            first_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // clock presence
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            idle_q <= 16'(LOST_CYC);
        end else if (edge_in) begin
            idle_q <= 16'h0000;
        end else if (idle_q < 16'(LOST_CYC)) begin
            idle_q <= idle_q + 16'h0001;
        end
    end

    assign alive_out = (idle_q < 16'(LOST_CYC));

endmodule

// ==== gcca_eb_partner.sv ====
module gcca_eb_partner (
    input logic clk_sys_in,
    input logic rst_b_in,
    input logic style_in,
    input logic slow_in,
    input logic req_in,
    input logic data_oe_b_in,
    input logic [gcca_pkg::GCCA_EB_AW-1:0] addr_in,
    output logic grant_out,
    output logic [31:0] data_out
);
    import gcca_pkg::*;
    logic [2:0] wait_q;
    logic on;
    logic g;
    assign on = style_in ? req_in : !req_in;
    assign g = on && wait_q >= (slow_in ? 3'h6 : 3'h1);
    // grant level follows the bus style
    assign grant_out = g ~^ style_in;
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wait_q <= '0;
            data_out <= '1;
        end else begin
            wait_q <= !on ? 3'h0 : (wait_q == 3'h7 ? wait_q : wait_q + 3'h1);
            // bus toggles every cycle unless granted with the data bus released by the master
            if (g && data_oe_b_in) begin
                data_out <= {12'ha5a, addr_in};
            end else begin
                data_out <= ~data_out;
            end
        end
    end
endmodule

// ==== gcca_grp_ram.sv ====
module gcca_grp_ram
    import gcca_pkg::*;
#(
    parameter int AW = GCCA_RAM_AW + 3
) (
    input wire logic clk_sys_in,
    input wire logic wr_in,
    input wire logic [AW-1:0] addr_in,
    input wire logic [31:0] wdata_in,
    output logic [31:0] rdata_out
);

    if (AW < 1 || AW > 16) begin : g_bad_aw
        $error("AW out of range");
    end

    logic [31:0] mem_q [2**AW];

    always_ff @(posedge clk_sys_in) begin
        if (wr_in) begin
            mem_q[addr_in] <= wdata_in;
        end
        rdata_out <= mem_q[addr_in];
    end

endmodule

// ==== gcca_monitor.sv ====
module gcca_monitor (
    input logic clk_sys_in,
    input logic rst_b_in,
    input logic reg_rd_in,
    input logic reg_wr_in,
    input logic [31:0] reg_wdata_in,
    input logic [31:0] reg_rdata_out,
    input gcca_pkg::gcca_ram_req_t ram_req_in,
    input logic ram_rvalid_out,
    input logic irq_a_src_in,
    input logic irq_a_oe_b_out,
    input logic dma_wr_req_in,
    input gcca_pkg::gcca_dma_kind_t dma_wr_kind_in,
    input logic dma_wr_refused_out,
    input logic exp_clock_oe_b_out,
    input logic eb_done_out,
    input logic eb_ready_out,
    input logic [gcca_pkg::GCCA_EB_AW-1:0] exp_addr_out,
    input logic exp_addr_mark_out,
    input logic exp_data_mark_out
);
    import gcca_pkg::*;
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_b_in);
    sequence s_release;
        !eb_ready_out [*4];
    endsequence
    property p_rel_hold; eb_done_out |-> s_release; endproperty
    property p_rel_end; eb_done_out |-> ##[4:12] eb_ready_out; endproperty
    property p_clk_en; reg_wr_in |=> exp_clock_oe_b_out == !$past(reg_wdata_in[11]); endproperty
    property p_rsvd; reg_rd_in |=> reg_rdata_out[15] == 1'b0 && reg_rdata_out[7] == 1'b0; endproperty
    property p_ram; ram_req_in.rd |=> ram_rvalid_out; endproperty
    property p_irq; !irq_a_src_in |=> irq_a_oe_b_out; endproperty
    property p_dma; dma_wr_req_in |-> dma_wr_refused_out == (dma_wr_kind_in == GCCA_WR_OTHER); endproperty
    property p_addr; !exp_addr_mark_out && !$past(exp_addr_mark_out) |-> $stable(exp_addr_out); endproperty
    property p_strobe; $fell(exp_data_mark_out) |=> exp_data_mark_out; endproperty
    a_rel_hold: assert property (p_rel_hold) else $error("bus retaken early");
    a_rel_end: assert property (p_rel_end) else $error("release wait too long");
    a_clk_en: assert property (p_clk_en) else $error("clock enable wrong");
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
    a_ram: assert property (p_ram) else $error("ram read lost");
    a_irq: assert property (p_irq) else $error("irq driven without source");
    a_dma: assert property (p_dma) else $error("dma write kind wrong");
    a_addr: assert property (p_addr) else $error("address moved while marked");
    a_strobe: assert property (p_strobe) else $error("strobe too long");
endmodule

bind gcca_top gcca_monitor gcca_monitor_i (.clk_sys_in, .rst_b_in, .reg_rd_in, .reg_wr_in, .reg_wdata_in,
    .reg_rdata_out, .ram_req_in, .ram_rvalid_out, .irq_a_src_in, .irq_a_oe_b_out, .dma_wr_req_in,
    .dma_wr_kind_in, .dma_wr_refused_out, .exp_clock_oe_b_out, .eb_done_out, .eb_ready_out, .exp_addr_out,
    .exp_addr_mark_out, .exp_data_mark_out);

// ==== gcca_pkg.sv ====
package gcca_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int GCCA_NGRP = 8;
    localparam int GCCA_RAM_AW = 8;
    localparam int GCCA_EB_AW = 20;

    // ------------------------------------------------------------
    // global settings field positions
    // ------------------------------------------------------------
    localparam int GCCA_RX_LO_POS = 16;
    localparam int GCCA_TX_LO_POS = 20;
    localparam int GCCA_RX_HI_POS = 24;
    localparam int GCCA_TX_HI_POS = 28;
    localparam int GCCA_REL_WAIT_POS = 12;
    localparam int GCCA_EXP_CLK_EN_POS = 11;
    localparam int GCCA_STYLE_POS = 10;
    localparam int GCCA_ADDR_HOLD_POS = 8;
    localparam int GCCA_DATA_HOLD_POS = 4;
    localparam int GCCA_IRQ_A_MASK_POS = 3;
    localparam int GCCA_IRQ_B_MASK_POS = 2;

    // ------------------------------------------------------------
    // reset values and constants
    // ------------------------------------------------------------
    localparam logic [31:0] GCCA_GLOBAL_RESET = 32'h0000_0000;
    localparam logic [31:0] GCCA_DEAD_WORD = 32'hdead_acce;
    localparam logic [3:0] GCCA_REL_WAIT_BASE = 4'h4;
    localparam logic [1:0] GCCA_MAP_SHARE2 = 2'h1;
    localparam logic [1:0] GCCA_MAP_SHARE4 = 2'h2;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int GCCA_CLK_PERIOD_NS = 10;
    localparam int GCCA_LINE_CLK_LOST_NS = 1000;
    localparam int GCCA_LINE_CLK_LOST_CYC = GCCA_LINE_CLK_LOST_NS / GCCA_CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] rel_wait;
        logic exp_clock_enable;
        logic exp_bus_style;
        logic [1:0] addr_hold_len;
        logic [2:0] data_hold_len;
        logic irq_a_mask;
        logic irq_b_mask;
    } gcca_cfg_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [2:0] grp;
        logic [GCCA_RAM_AW-1:0] addr;
        logic [31:0] wdata;
    } gcca_ram_req_t;

    typedef struct packed {
        logic vld;
        logic we;
        logic [GCCA_EB_AW-1:0] addr;
        logic [31:0] wdata;
    } gcca_eb_req_t;

    typedef enum logic [1:0] {
        GCCA_WR_MSG_PTR = 2'h0,
        GCCA_WR_BUF_STATUS = 2'h1,
        GCCA_WR_RX_DATA = 2'h2,
        GCCA_WR_OTHER = 2'h3
    } gcca_dma_kind_t;

    typedef enum logic [2:0] {
        GCCA_EB_IDLE = 3'b000,
        GCCA_EB_REQ = 3'b001,
        GCCA_EB_ADDR = 3'b011,
        GCCA_EB_DATA = 3'b010,
        GCCA_EB_STROBE = 3'b110,
        GCCA_EB_RELEASE = 3'b111
    } gcca_eb_state_t;

endpackage

// ==== gcca_tb.sv ====
module gcca_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import gcca_pkg::*;
    logic clk_sys_in = 0, rst_b_in = 0, reg_rd_in = 0, reg_wr_in = 0, chip_reset_in = 0, sty = 0, sl = 0;
    logic irq_a_src_in = 0, irq_b_src_in = 0, dma_wr_req_in = 0, xg;
    logic [31:0] reg_wdata_in = '0, wv, v, xdi, act_m = '0, cfg_m = '0;
    logic [31:0] reg_rdata_out, ram_rdata_out, eb_rdata_out, exp_data_out;
    logic [15:0] lc = '0;
    logic [7:0] grp_reset_in = '0, a;
    logic [1:0] port_map_in = '0;
    gcca_ram_req_t ram_req_in = '0;
    gcca_dma_kind_t dma_wr_kind_in = GCCA_WR_MSG_PTR;
    gcca_eb_req_t eq = '0;
    logic [GCCA_EB_AW-1:0] exp_addr_out, ea;
    logic ram_rvalid_out, irq_a_oe_b_out, irq_b_oe_b_out, dma_wr_ok_out, dma_wr_refused_out, exp_clock_out;
    logic exp_clock_oe_b_out, eb_ready_out, eb_done_out, exp_req_out, exp_data_oe_b_out, exp_addr_mark_out;
    logic exp_data_mark_out, exp_dir_out, ia, ib;
    int error_cnt = 0, compares = 0, na, nd, n;
    int ec [2][8];
    gcca_top gcca_top_i (.clk_sys_in, .rst_b_in, .reg_rd_in, .reg_wr_in, .reg_wdata_in, .reg_rdata_out,
        .tx_line_clock_in(lc[7:0]), .rx_line_clock_in(lc[15:8]), .port_map_in, .grp_reset_in, .chip_reset_in,
        .ram_req_in, .ram_rdata_out, .ram_rvalid_out, .irq_a_src_in, .irq_b_src_in, .irq_a_out(ia),
        .irq_a_oe_b_out, .irq_b_out(ib), .irq_b_oe_b_out, .dma_wr_req_in, .dma_wr_kind_in, .dma_wr_ok_out,
        .dma_wr_refused_out, .exp_clock_out, .exp_clock_oe_b_out, .eb_req_in(eq), .eb_ready_out,
        .eb_done_out, .eb_rdata_out, .exp_req_out, .exp_grant_in(xg), .exp_addr_out, .exp_data_out,
        .exp_data_oe_b_out, .exp_data_in(xdi), .exp_addr_mark_out, .exp_dir_out, .exp_data_mark_out);
    gcca_eb_partner gcca_eb_partner_i (.clk_sys_in, .rst_b_in, .style_in(sty), .slow_in(sl),
        .req_in(exp_req_out), .data_oe_b_in(exp_data_oe_b_out), .addr_in(exp_addr_out), .grant_out(xg),
        .data_out(xdi));
    always #5 clk_sys_in = ~clk_sys_in;
    task automatic chk(input logic [31:0] g, e);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task automatic end_of_test;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic cy(input int k);
        repeat (k) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic rdr;
        cy(1);
        reg_rd_in = 1;
        cy(1);
        reg_rd_in = 0;
        chk(reg_rdata_out, act_m | cfg_m & 32'h0000_7f7c);
        act_m = '0;
        ec = '{default: 0};
    endtask
    task automatic wrc(input logic [31:0] d);
        cy(1);
        reg_wr_in = 1;
        reg_wdata_in = d;
        cy(1);
        reg_wr_in = 0;
        cfg_m = d;
    endtask
    // line i: 0-7 tx ports, 8-15 rx ports; model follows port map
    task automatic edg(input int i, k);
        repeat (k) begin
            lc[i] = 1;
            cy(4);
            lc[i] = 0;
            cy(4);
        end
        for (int g = 0; g < 8; g++) begin
            if ((port_map_in == 1 ? g / 2 : port_map_in == 2 ? g / 4 : g) == i % 8) begin
                ec[i / 8][g] += k;
                if (ec[i / 8][g] >= 2) act_m[g + (g < 4 ? 16 : 20) + (i < 8 ? 4 : 0)] = 1'b1;
            end
        end
        cy(2);
    endtask
    task automatic ram(input logic w, input logic [31:0] d, e);
        cy(1);
        ram_req_in = '{!w, w, 3'h2, a, d};
        cy(1);
        ram_req_in = '0;
        if (!w) chk(ram_rdata_out, e);
    endtask
    initial begin
        #200000;
        error_cnt++;
        end_of_test();
    end
    initial begin
        void'($urandom(41));
        cy(6);
        rst_b_in = 1;
        rdr();
        edg(3, 2);
        grp_reset_in[3] = 1;
        cy(1);
        grp_reset_in = '0;
        act_m = '0;
        rdr();
        edg(9, 2);
        chip_reset_in = 1;
        cy(1);
        chip_reset_in = 0;
        act_m = '0;
        rdr();
        for (int i = 0; i < 16; i++) begin
            edg(i, 1);
            rdr();
            edg(i, 2);
            rdr();
            rdr();
        end
        for (int m = 1; m < 3; m++) begin
            port_map_in = m[1:0];
            edg(0, 2);
            edg(15, 2);
            rdr();
        end
        port_map_in = '0;
        repeat (3) begin
            wrc($urandom);
            rdr();
        end
        irq_a_src_in = 1;
        irq_b_src_in = 1;
        for (int k = 0; k < 4; k++) begin
            wrc(32'(k[0]) << 11 | 32'(k[1]) << 3 | 32'(k[0]) << 2);
            cy(2);
            chk({ia, ib, irq_a_oe_b_out, irq_b_oe_b_out, exp_clock_oe_b_out}, {2'b00, k[1], k[0], !k[0]});
            if (k[0]) chk(exp_clock_out, !clk_sys_in);
        end
        irq_a_src_in = 0;
        irq_b_src_in = 0;
        dma_wr_req_in = 1;
        for (int k = 0; k < 4; k++) begin
            dma_wr_kind_in = gcca_dma_kind_t'(k);
            cy(1);
            chk({dma_wr_ok_out, dma_wr_refused_out}, k == 3 ? 2'b01 : 2'b10);
        end
        dma_wr_req_in = 0;
        a = $urandom;
        v = $urandom;
        edg(2, 2);
        ram(1, v, 0);
        ram(0, 0, v);
        cy(110);
        ram(1, ~v, 0);
        ram(0, 0, GCCA_DEAD_WORD);
        edg(2, 1);
        ram(0, 0, v);
        for (int k = 0; k < 4; k++) begin
            v = $urandom;
            ea = v[31:12];
            wv = $urandom;
            sl = k[0];
            wrc({17'h0, v[14:12], 1'b0, k[1], v[9:8], 1'b0, v[6:4], 4'h0});
            sty = k[1];
            cy(3);
            chk(exp_req_out, !k[1]);
            eq = '{1'b1, k[0], ea, wv};
            cy(1);
            eq = '0;
            na = 0;
            nd = 0;
            n = 0;
            while (!eb_done_out && n < 300) begin
                if (exp_addr_mark_out && exp_addr_out === ea) na++;
                if (!exp_addr_mark_out && exp_data_mark_out && (exp_dir_out || !sty)) nd++;
                if (k[0] && !(sty ? exp_dir_out : exp_data_mark_out)) begin
                    chk(exp_data_out, wv);
                    chk(exp_data_oe_b_out, 0);
                end
                n++;
                cy(1);
            end
            chk(eb_done_out, 1);
            chk(na >= v[9:8] + 1, 1);
            chk(nd, v[6:4] + 1);
            if (!k[0]) chk(eb_rdata_out, {12'ha5a, ea});
            n = 0;
            while (!eb_ready_out && n < 50) begin
                n++;
                cy(1);
            end
            chk(n, v[14:12] + 4);
        end
        end_of_test();
    end
endmodule

// ==== gcca_top.sv ====
module gcca_top (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic reg_rd_in,
    input wire logic reg_wr_in,
    input wire logic [31:0] reg_wdata_in,
    output logic [31:0] reg_rdata_out,
    input wire logic [gcca_pkg::GCCA_NGRP-1:0] tx_line_clock_in,
    input wire logic [gcca_pkg::GCCA_NGRP-1:0] rx_line_clock_in,
    input wire logic [1:0] port_map_in,
    input wire logic [gcca_pkg::GCCA_NGRP-1:0] grp_reset_in,
    input wire logic chip_reset_in,
    input wire gcca_pkg::gcca_ram_req_t ram_req_in,
    output logic [31:0] ram_rdata_out,
    output logic ram_rvalid_out,
    input wire logic irq_a_src_in,
    input wire logic irq_b_src_in,
    output logic irq_a_out,
    output logic irq_a_oe_b_out,
    output logic irq_b_out,
    output logic irq_b_oe_b_out,
    input wire logic dma_wr_req_in,
    input wire gcca_pkg::gcca_dma_kind_t dma_wr_kind_in,
    output logic dma_wr_ok_out,
    output logic dma_wr_refused_out,
    output logic exp_clock_out,
    output logic exp_clock_oe_b_out,
    input wire gcca_pkg::gcca_eb_req_t eb_req_in,
    output logic eb_ready_out,
    output logic eb_done_out,
    output logic [31:0] eb_rdata_out,
    output logic exp_req_out,
    input wire logic exp_grant_in,
    output logic [gcca_pkg::GCCA_EB_AW-1:0] exp_addr_out,
    output logic [31:0] exp_data_out,
    output logic exp_data_oe_b_out,
    input wire logic [31:0] exp_data_in,
    output logic exp_addr_mark_out,
    output logic exp_dir_out,
    output logic exp_data_mark_out
);
    import gcca_pkg::*;
    localparam int NG = GCCA_NGRP;
    gcca_cfg_t cfg_q;
    logic [NG-1:0] tx_seen, rx_seen, tx_alive, rx_alive;
    logic [NG-1:0] tx_edge, rx_edge, tx_grp_edge, rx_grp_edge;
    logic [NG-1:0] act_clr;
    logic [2:0] tx_s0_q [NG];
    logic [2:0] rx_s0_q [NG];

    // ------------------------------------------------------------
    // line clock synchronisers and edge detect
    // ------------------------------------------------------------
    generate
        for (genvar p = 0; p < NG; p++) begin : g_port
            always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    tx_s0_q[p] <= 3'h0;
                    rx_s0_q[p] <= 3'h0;
                end else begin
                    tx_s0_q[p] <= {tx_s0_q[p][1:0], tx_line_clock_in[p]};
                    rx_s0_q[p] <= {rx_s0_q[p][1:0], rx_line_clock_in[p]};
                end
            end
            assign tx_edge[p] = tx_s0_q[p][1] & ~tx_s0_q[p][2];
            assign rx_edge[p] = rx_s0_q[p][1] & ~rx_s0_q[p][2];
        end
    endgenerate

    function automatic logic [2:0] drive_port(input logic [2:0] grp, input logic [1:0] pmap);
        unique case (pmap)
            GCCA_MAP_SHARE2: drive_port = grp >> 1;
            GCCA_MAP_SHARE4: drive_port = grp >> 2;
            default: drive_port = grp;
        endcase
    endfunction

    // ------------------------------------------------------------
    // per group activity detectors
    // ------------------------------------------------------------
    generate
        for (genvar g = 0; g < NG; g++) begin : g_grp
            assign tx_grp_edge[g] = tx_edge[drive_port(3'(g), port_map_in)];
            assign rx_grp_edge[g] = rx_edge[drive_port(3'(g), port_map_in)];
            assign act_clr[g] = reg_rd_in | grp_reset_in[g] | chip_reset_in;

            gcca_clk_seen #(
                .LOST_CYC(GCCA_LINE_CLK_LOST_CYC)
            ) u_tx_seen (
                .clk_sys_in(clk_sys_in),
                .rst_b_in(rst_b_in),
                .edge_in(tx_grp_edge[g]),
                .clr_in(act_clr[g]),
                .seen_out(tx_seen[g]),
                .alive_out(tx_alive[g])
            );
            gcca_clk_seen #(
                .LOST_CYC(GCCA_LINE_CLK_LOST_CYC)
            ) u_rx_seen (
                .clk_sys_in(clk_sys_in),
                .rst_b_in(rst_b_in),
                .edge_in(rx_grp_edge[g]),
                .clr_in(act_clr[g]),
                .seen_out(rx_seen[g]),
                .alive_out(rx_alive[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // global settings register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cfg_q <= gcca_cfg_t'(GCCA_GLOBAL_RESET[11:0]);
        end else if (reg_wr_in) begin
            cfg_q.rel_wait <= reg_wdata_in[GCCA_REL_WAIT_POS +: 3];
            cfg_q.exp_clock_enable <= reg_wdata_in[GCCA_EXP_CLK_EN_POS];
            cfg_q.exp_bus_style <= reg_wdata_in[GCCA_STYLE_POS];
            cfg_q.addr_hold_len <= reg_wdata_in[GCCA_ADDR_HOLD_POS +: 2];
            cfg_q.data_hold_len <= reg_wdata_in[GCCA_DATA_HOLD_POS +: 3];
            cfg_q.irq_a_mask <= reg_wdata_in[GCCA_IRQ_A_MASK_POS];
            cfg_q.irq_b_mask <= reg_wdata_in[GCCA_IRQ_B_MASK_POS];
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            reg_rdata_out <= 32'h0000_0000;
        end else if (reg_rd_in) begin
            reg_rdata_out <= 32'h0000_0000;
            reg_rdata_out[GCCA_TX_HI_POS +: 4] <= tx_seen[7:4];
            reg_rdata_out[GCCA_RX_HI_POS +: 4] <= rx_seen[7:4];
            reg_rdata_out[GCCA_TX_LO_POS +: 4] <= tx_seen[3:0];
            reg_rdata_out[GCCA_RX_LO_POS +: 4] <= rx_seen[3:0];
            reg_rdata_out[GCCA_REL_WAIT_POS +: 3] <= cfg_q.rel_wait;
            reg_rdata_out[GCCA_EXP_CLK_EN_POS] <= cfg_q.exp_clock_enable;
            reg_rdata_out[GCCA_STYLE_POS] <= cfg_q.exp_bus_style;
            reg_rdata_out[GCCA_ADDR_HOLD_POS +: 2] <= cfg_q.addr_hold_len;
            reg_rdata_out[GCCA_DATA_HOLD_POS +: 3] <= cfg_q.data_hold_len;
            reg_rdata_out[GCCA_IRQ_A_MASK_POS] <= cfg_q.irq_a_mask;
            reg_rdata_out[GCCA_IRQ_B_MASK_POS] <= cfg_q.irq_b_mask;
        end
    end

    // ------------------------------------------------------------
    // channel group ram
    // ------------------------------------------------------------
    logic grp_live;
    logic ram_wr;
    logic dead_q;
    logic [31:0] ram_q;
    assign grp_live = tx_alive[ram_req_in.grp] | rx_alive[ram_req_in.grp];
    assign ram_wr = ram_req_in.wr & grp_live;
    gcca_grp_ram #(
        .AW(GCCA_RAM_AW + 3)
    ) u_ram (
        .clk_sys_in(clk_sys_in),
        .wr_in(ram_wr),
        .addr_in({ram_req_in.grp, ram_req_in.addr}),
        .wdata_in(ram_req_in.wdata),
        .rdata_out(ram_q)
    );
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ram_rvalid_out <= 1'b0;
            dead_q <= 1'b0;
        end else begin
            ram_rvalid_out <= ram_req_in.rd;
            dead_q <= ~grp_live;
        end
    end
    assign ram_rdata_out = dead_q ? GCCA_DEAD_WORD : ram_q;

    // ------------------------------------------------------------
    // interrupt pins and master write filter
    // ------------------------------------------------------------
    // masks gate interrupts
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_a_oe_b_out <= 1'b1;
            irq_b_oe_b_out <= 1'b1;
        end else begin
            irq_a_oe_b_out <= ~(irq_a_src_in & ~cfg_q.irq_a_mask);
            irq_b_oe_b_out <= ~(irq_b_src_in & ~cfg_q.irq_b_mask);
        end
    end
    assign irq_a_out = 1'b0;
    assign irq_b_out = 1'b0;

    assign dma_wr_ok_out = dma_wr_req_in & (dma_wr_kind_in != GCCA_WR_OTHER);
    assign dma_wr_refused_out = dma_wr_req_in & (dma_wr_kind_in == GCCA_WR_OTHER);

    // ------------------------------------------------------------
    // expansion clock
    // ------------------------------------------------------------
    // inverted clock or floated
    assign exp_clock_out = ~clk_sys_in;
    assign exp_clock_oe_b_out = ~cfg_q.exp_clock_enable;

    // ------------------------------------------------------------
    // expansion bus sequencer
    // ------------------------------------------------------------
    gcca_eb_state_t eb_state_q;
    logic [3:0] eb_cnt_q;
    logic grant_s1_q, grant_s2_q;
    logic [31:0] din_s1_q, din_s2_q;
    logic eb_we_q, eb_style_q, granted;

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            grant_s1_q <= 1'b0;
            grant_s2_q <= 1'b0;
            din_s1_q <= 32'h0000_0000;
            din_s2_q <= 32'h0000_0000;
        end else begin
            grant_s1_q <= exp_grant_in;
            grant_s2_q <= grant_s1_q;
            din_s1_q <= exp_data_in;
            din_s2_q <= din_s1_q;
        end
    end

    assign granted = eb_style_q ? grant_s2_q : ~grant_s2_q;
    assign eb_ready_out = (eb_state_q == GCCA_EB_IDLE);

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            eb_state_q <= GCCA_EB_IDLE;
            eb_cnt_q <= 4'h0;
            eb_we_q <= 1'b0;
            eb_style_q <= 1'b0;
            exp_addr_out <= '0;
            exp_data_out <= 32'h0000_0000;
            eb_rdata_out <= 32'h0000_0000;
            eb_done_out <= 1'b0;
        end else begin
            eb_done_out <= 1'b0;
            unique case (eb_state_q)
                GCCA_EB_IDLE: begin
                    eb_style_q <= cfg_q.exp_bus_style;
                    if (eb_req_in.vld) begin
                        eb_we_q <= eb_req_in.we;
                        exp_addr_out <= eb_req_in.addr;
                        exp_data_out <= eb_req_in.wdata;
                        eb_state_q <= GCCA_EB_REQ;
                    end
                end
                GCCA_EB_REQ: begin
                    if (granted) begin
                        eb_cnt_q <= {2'b00, cfg_q.addr_hold_len};
                        eb_state_q <= GCCA_EB_ADDR;
                    end
                end
                GCCA_EB_ADDR: begin
                    if (eb_cnt_q == 4'h0) begin
                        eb_cnt_q <= {1'b0, cfg_q.data_hold_len};
                        eb_state_q <= GCCA_EB_DATA;
                    end else begin
                        eb_cnt_q <= eb_cnt_q - 4'h1;
                    end
                end
                GCCA_EB_DATA: begin
                    if (eb_cnt_q == 4'h0) begin
                        eb_state_q <= GCCA_EB_STROBE;
                    end else begin
                        eb_cnt_q <= eb_cnt_q - 4'h1;
                    end
                end
                GCCA_EB_STROBE: begin
                    eb_rdata_out <= din_s2_q;
                    eb_done_out <= 1'b1;
                    eb_cnt_q <= GCCA_REL_WAIT_BASE + {1'b0, cfg_q.rel_wait} - 4'h1;
                    eb_state_q <= GCCA_EB_RELEASE;
                end
                GCCA_EB_RELEASE: begin
                    if (eb_cnt_q == 4'h0) begin
                        eb_state_q <= GCCA_EB_IDLE;
                    end else begin
                        eb_cnt_q <= eb_cnt_q - 4'h1;
                    end
                end
                default: eb_state_q <= GCCA_EB_IDLE;
            endcase
        end
    end

    always_comb begin
        logic req_on, addr_on, strobe_on;
        req_on = (eb_state_q != GCCA_EB_IDLE) && (eb_state_q != GCCA_EB_RELEASE);
        addr_on = (eb_state_q == GCCA_EB_DATA) || (eb_state_q == GCCA_EB_STROBE);
        strobe_on = (eb_state_q == GCCA_EB_STROBE);
        exp_data_oe_b_out = ~(req_on & eb_we_q & (eb_state_q != GCCA_EB_REQ));
        if (eb_style_q) begin
            exp_req_out = req_on;
            exp_addr_mark_out = ~addr_on;
            exp_dir_out = ~(strobe_on & eb_we_q);
            exp_data_mark_out = ~(strobe_on & ~eb_we_q);
        end else begin
            exp_req_out = ~req_on;
            exp_addr_mark_out = ~addr_on;
            exp_dir_out = ~eb_we_q;
            exp_data_mark_out = ~strobe_on;
        end
    end

endmodule
